// >>> prio_map_lookup.sv
// Purpose: Turns a frame's 3-bit 802.1p value into its 2-bit internal priority.
// Assumes: Map registers are stable or change between requests.
// Notes:   Result and valid are registered one cycle after the request.
`timescale 1ns/10ps
module prio_map_lookup (
    input  wire logic                                       mclk,
    input  wire logic                                       resetn,
    input  wire logic [switch_global_control_pkg::DATA_W-1:0] map_lower,
    input  wire logic [switch_global_control_pkg::DATA_W-1:0] map_upper,
    input  wire logic                                       req_valid,
    input  wire logic [switch_global_control_pkg::PCP_W-1:0]  req_pcp,
    output logic      [switch_global_control_pkg::PRIO_W-1:0] prio_ff,
    output logic                                            prio_valid_ff
);
    import switch_global_control_pkg::*;

    logic [2*DATA_W-1:0] map_all;
    logic [PRIO_W-1:0]   field [MAP_N];
    logic [PRIO_W-1:0]   nxt_prio;

    assign map_all = {map_upper, map_lower};

    // Entry n sits at bits 2n+1..2n of the joined maps.
    for (genvar n = 0; n < MAP_N; n++) begin : g_field
        assign field[n] = map_all[PRIO_W*n +: PRIO_W];
    end

    assign nxt_prio = field[req_pcp];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prio_ff       <= '0;
            prio_valid_ff <= 1'b0;
        end else begin
            prio_valid_ff <= req_valid;
            if (req_valid) begin
                prio_ff <= nxt_prio;
            end
        end
    end

endmodule : prio_map_lookup

// >>> switch_global_control_pkg.sv
// Purpose: Shared constants for the global priority, forwarding, pad and PHY address registers.
// Assumes: Byte-wide registers selected by an 8-bit register index.
// Notes:   Every register offset, register reset value and control-byte field position lives here.
package switch_global_control_pkg;

    // ------------------------------------------------------------------
    // Register access widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PCP_W  = 3;
    localparam int PRIO_W = 2;
    localparam int PORT_N = 3;
    localparam int PHY_W  = 5;
    localparam int MAP_N  = 8;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_MAP_LOWER = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY_MAP_UPPER = 8'h0D;
    localparam logic [ADDR_W-1:0] OFS_UNKNOWN_DEST_PAD   = 8'h0E;
    localparam logic [ADDR_W-1:0] OFS_PHY_BASE_ADDRESS   = 8'h0F;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    // Lower map holds pcp 3..0 as 01,01,00,00; upper map holds 7..4 as 11,11,10,10.
    localparam logic [DATA_W-1:0] RST_PRIORITY_MAP_LOWER = 8'h50;
    localparam logic [DATA_W-1:0] RST_PRIORITY_MAP_UPPER = 8'hFA;
    localparam logic              RST_UNKNOWN_ENABLE     = 1'h0;
    localparam logic              RST_PAD_DRIVE_16MA     = 1'h1;
    localparam logic [PORT_N-1:0] RST_UNKNOWN_PORT_MASK  = 3'h7;
    localparam logic [PHY_W-1:0]  RST_PHY_BASE           = 5'h01;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_UNKNOWN_ENABLE = 7;
    localparam int BIT_PAD_DRIVE      = 6;
    localparam int LSB_UNKNOWN_MASK   = 0;
    localparam int LSB_PHY_BASE       = 3;

    // ------------------------------------------------------------------
    // PHY address code limits and reserved read values
    // ------------------------------------------------------------------
    localparam logic [PHY_W-1:0]  PHY_CODE_MIN  = 5'h01;
    localparam logic [PHY_W-1:0]  PHY_CODE_MAX  = 5'h1D;
    localparam logic [PHY_W-1:0]  PHY_STEP      = 5'h01;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
    localparam logic [2:0]        RSVD_ZERO3    = 3'h0;

endpackage : switch_global_control_pkg

// >>> switch_global_control_properties.sv
// Purpose: Port-level properties of the global control register bank.
// Assumes: One clock; reset is asynchronous and active low.
// Notes:   The map check waits for a cycle without reg_wr so no later write can replace the written byte.
`timescale 1ns/10ps
module switch_global_control_checker
    import switch_global_control_pkg::*;
(
    input wire logic              mclk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata_ff,
    input wire logic              reg_rvalid_ff,
    input wire logic              prio_req,
    input wire logic [PCP_W-1:0]  prio_req_pcp,
    input wire logic [PRIO_W-1:0] prio_ff,
    input wire logic              fwd_req,
    input wire logic              fwd_dest_unknown,
    input wire logic [PORT_N-1:0] fwd_flood_ports,
    input wire logic [PORT_N-1:0] fwd_ports_ff,
    input wire logic              fwd_valid_ff,
    input wire logic              pad_drive_16ma_ff,
    input wire logic [PHY_W-1:0]  phy_addr_port1_ff,
    input wire logic [PHY_W-1:0]  phy_addr_port2_ff,
    input wire logic              phy_addr_invalid_ff
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    property p_rsvd_unknown;
        reg_rd && reg_addr == OFS_UNKNOWN_DEST_PAD |=> reg_rvalid_ff && reg_rdata_ff[5:3] == 3'h0;
    endproperty
    a_rsvd_unknown: assert property (p_rsvd_unknown) else $error("reserved bits set");
    property p_rsvd_phy;
        reg_rd && reg_addr == OFS_PHY_BASE_ADDRESS |=> reg_rvalid_ff && reg_rdata_ff[2:0] == 3'h0;
    endproperty
    a_rsvd_phy: assert property (p_rsvd_phy) else $error("reserved bits set");
    property p_pad;
        reg_wr && reg_addr == OFS_UNKNOWN_DEST_PAD |=> pad_drive_16ma_ff == $past(reg_wdata[6]);
    endproperty
    a_pad: assert property (p_pad) else $error("pad drive not updated");
    property p_port2;
        phy_addr_port2_ff == phy_addr_port1_ff + PHY_STEP;
    endproperty
    a_port2: assert property (p_port2) else $error("port 2 address wrong");
    property p_invalid;
        phy_addr_invalid_ff == !(phy_addr_port1_ff inside {[PHY_CODE_MIN:PHY_CODE_MAX]});
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid flag wrong");
    property p_fwd_known;
        fwd_req && !fwd_dest_unknown |=> fwd_valid_ff && fwd_ports_ff == $past(fwd_flood_ports);
    endproperty
    a_fwd_known: assert property (p_fwd_known) else $error("known frame ports changed");
    property p_fwd_idle;
        !fwd_req |=> !fwd_valid_ff;
    endproperty
    a_fwd_idle: assert property (p_fwd_idle) else $error("forward valid without request");
    property p_map_zero;
        reg_wr && reg_addr == OFS_PRIORITY_MAP_LOWER ##1 !reg_wr ##1 prio_req && prio_req_pcp == 3'h0
            |=> prio_ff == $past(reg_wdata[1:0], 3);
    endproperty
    a_map_zero: assert property (p_map_zero) else $error("new map not used");
endmodule : switch_global_control_checker
bind switch_global_control_regs switch_global_control_checker chk_i (.*);

// >>> switch_global_control_regs.sv
// Purpose: Global priority remap, unknown-destination forwarding, pad drive and PHY base address.
// Assumes: A management engine drives single-cycle read and write strobes with an index.
// Notes:   Reads answer one cycle after the strobe; writes take effect on the next edge.
`timescale 1ns/10ps

// Behaviour
// - pcp zero uses lower bits 1-0, reset 00
// - pcp one uses lower bits 3-2, reset 00
// - pcp two uses lower bits 5-4, reset 01
// - pcp three uses lower bits 7-6, reset 01
// - pcp four uses upper bits 1-0, reset 10
// - pcp five uses upper bits 3-2, reset 10
// - pcp six uses upper bits 5-4, reset 11
// - pcp seven uses upper bits 7-6, reset 11
// - enable bit 7 sends unknown frames to mask
// - port mask bits 2-0, reset 111
// - mask one includes port, zero excludes
// - bit 6 picks 16 mA or 8 mA drive
// - bits 5-3 read zero, software leaves alone
// - port 1 PHY address bits 7-3, reset 00001
// - port 2 PHY address is port 1 plus one
// - PHY register bits 2-0 read 000
module switch_global_control_regs (
    input  wire logic                                        mclk,
    input  wire logic                                        resetn,
    input  wire logic [switch_global_control_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                                        reg_wr,
    input  wire logic [switch_global_control_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                                        reg_rd,
    output logic      [switch_global_control_pkg::DATA_W-1:0] reg_rdata_ff,
    output logic                                             reg_rvalid_ff,
    input  wire logic                                        prio_req,
    input  wire logic [switch_global_control_pkg::PCP_W-1:0]  prio_req_pcp,
    output logic      [switch_global_control_pkg::PRIO_W-1:0] prio_ff,
    output logic                                             prio_valid_ff,
    input  wire logic                                        fwd_req,
    input  wire logic                                        fwd_dest_unknown,
    input  wire logic [switch_global_control_pkg::PORT_N-1:0] fwd_flood_ports,
    output logic      [switch_global_control_pkg::PORT_N-1:0] fwd_ports_ff,
    output logic                                             fwd_valid_ff,
    output logic                                             pad_drive_16ma_ff,
    output logic      [switch_global_control_pkg::PHY_W-1:0]  phy_addr_port1_ff,
    output logic      [switch_global_control_pkg::PHY_W-1:0]  phy_addr_port2_ff,
    output logic                                             phy_addr_invalid_ff
);
    import switch_global_control_pkg::*;

    // ------------------------------------------------------------------
    // Stored configuration
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] map_lower_ff;
    logic [DATA_W-1:0] map_upper_ff;
    logic              unknown_enable_ff;
    logic [PORT_N-1:0] unknown_mask_ff;
    logic [PHY_W-1:0]  phy_base_ff;

    logic              wr_map_lower;
    logic              wr_map_upper;
    logic              wr_unknown;
    logic              wr_phy;
    logic [DATA_W-1:0] nxt_rdata;
    logic [PORT_N-1:0] nxt_fwd_ports;
    logic [PHY_W-1:0]  nxt_phy_port2;
    logic              nxt_phy_invalid;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    assign wr_map_lower = reg_wr && (reg_addr == OFS_PRIORITY_MAP_LOWER);
    assign wr_map_upper = reg_wr && (reg_addr == OFS_PRIORITY_MAP_UPPER);
    assign wr_unknown   = reg_wr && (reg_addr == OFS_UNKNOWN_DEST_PAD);
    assign wr_phy       = reg_wr && (reg_addr == OFS_PHY_BASE_ADDRESS);

    // All four remap fields of each half are written together as one byte.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            map_lower_ff <= RST_PRIORITY_MAP_LOWER;
            map_upper_ff <= RST_PRIORITY_MAP_UPPER;
        end else begin
            if (wr_map_lower) begin
                map_lower_ff <= reg_wdata;
            end
            if (wr_map_upper) begin
                map_upper_ff <= reg_wdata;
            end
        end
    end

    // Bits 5-3 are not stored, so a write to them is simply lost.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            unknown_enable_ff <= RST_UNKNOWN_ENABLE;
            pad_drive_16ma_ff <= RST_PAD_DRIVE_16MA;
            unknown_mask_ff   <= RST_UNKNOWN_PORT_MASK;
        end else if (wr_unknown) begin
            unknown_enable_ff <= reg_wdata[BIT_UNKNOWN_ENABLE];
            pad_drive_16ma_ff <= reg_wdata[BIT_PAD_DRIVE];
            unknown_mask_ff   <= reg_wdata[LSB_UNKNOWN_MASK +: PORT_N];
        end
    end

    // Out-of-range codes are stored as written; the flag lets the PHY
    // management logic refuse them rather than hiding the value from software.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phy_base_ff <= RST_PHY_BASE;
        end else if (wr_phy) begin
            phy_base_ff <= reg_wdata[LSB_PHY_BASE +: PHY_W];
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rdata = READ_UNMAPPED;
        unique case (reg_addr)
            OFS_PRIORITY_MAP_LOWER: begin
                nxt_rdata = map_lower_ff;
            end
            OFS_PRIORITY_MAP_UPPER: begin
                nxt_rdata = map_upper_ff;
            end
            OFS_UNKNOWN_DEST_PAD: begin
                nxt_rdata = {unknown_enable_ff, pad_drive_16ma_ff, RSVD_ZERO3,
                             unknown_mask_ff};
            end
            OFS_PHY_BASE_ADDRESS: begin
                nxt_rdata = {phy_base_ff, RSVD_ZERO3};
            end
            default: begin
                nxt_rdata = READ_UNMAPPED;
            end
        endcase
    end

    // Read data are held until the next read so a slow serial engine can
    // shift them out at its own pace.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_ff  <= READ_UNMAPPED;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Priority remap
    // ------------------------------------------------------------------
    prio_map_lookup u_prio_map_lookup (
        .mclk          (mclk),
        .resetn        (resetn),
        .map_lower     (map_lower_ff),
        .map_upper     (map_upper_ff),
        .req_valid     (prio_req),
        .req_pcp       (prio_req_pcp),
        .prio_ff       (prio_ff),
        .prio_valid_ff (prio_valid_ff)
    );

    // ------------------------------------------------------------------
    // Unknown-destination forwarding
    // ------------------------------------------------------------------
    // With the feature off, an unknown frame floods as the lookup proposed.
    always_comb begin
        nxt_fwd_ports = fwd_flood_ports;
        if (fwd_dest_unknown && unknown_enable_ff) begin
            nxt_fwd_ports = unknown_mask_ff;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fwd_ports_ff <= '0;
            fwd_valid_ff <= 1'b0;
        end else begin
            fwd_valid_ff <= fwd_req;
            if (fwd_req) begin
                fwd_ports_ff <= nxt_fwd_ports;
            end
        end
    end

    // ------------------------------------------------------------------
    // PHY addresses
    // ------------------------------------------------------------------
    assign nxt_phy_port2   = phy_base_ff + PHY_STEP;
    assign nxt_phy_invalid = (phy_base_ff < PHY_CODE_MIN) || (phy_base_ff > PHY_CODE_MAX);

    // These outputs trail the stored field by one cycle.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phy_addr_port1_ff   <= RST_PHY_BASE;
            phy_addr_port2_ff   <= RST_PHY_BASE + PHY_STEP;
            phy_addr_invalid_ff <= 1'b0;
        end else begin
            phy_addr_port1_ff   <= phy_base_ff;
            phy_addr_port2_ff   <= nxt_phy_port2;
            phy_addr_invalid_ff <= nxt_phy_invalid;
        end
    end

endmodule : switch_global_control_regs

// >>> tb.sv
// Purpose: Directed bench for the global control register bank.
// Assumes: Each strobe lasts one cycle and is followed by two idle cycles.
// Notes:   Checks sample at the falling edge, after registered outputs settle.
`timescale 1ns/10ps
module tb;
    import switch_global_control_pkg::*;
    localparam logic [7:0] LO = OFS_PRIORITY_MAP_LOWER, UP = OFS_PRIORITY_MAP_UPPER;
    localparam logic [7:0] UD = OFS_UNKNOWN_DEST_PAD, PH = OFS_PHY_BASE_ADDRESS;
    logic       mclk, resetn, reg_wr, reg_rd, prio_req, fwd_req, fwd_dest_unknown;
    logic       reg_rvalid_ff, prio_valid_ff, fwd_valid_ff, pad_drive_16ma_ff, phy_addr_invalid_ff;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
    logic [2:0] prio_req_pcp, fwd_flood_ports, fwd_ports_ff;
    logic [1:0] prio_ff;
    logic [4:0] phy_addr_port1_ff, phy_addr_port2_ff;
    int         mismatches = 0, cmp_count = 0;
    switch_global_control_regs dut (.*);
    initial forever #25 mclk = ~mclk;
    initial begin
        repeat (2000) @(posedge mclk);
        mismatches++;
        final_report();
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        mismatches += int'(got !== exp);
    endtask : chk
    // Kind 0 writes, 1 reads, 2 looks up a priority, 3 asks for a forwarding decision.
    task automatic op(input int k, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge mclk);
        {reg_wr, reg_rd, prio_req, fwd_req} <= 4'h8 >> k;
        reg_addr         <= a;
        reg_wdata        <= d;
        prio_req_pcp     <= a[2:0];
        fwd_dest_unknown <= a[0];
        fwd_flood_ports  <= d[2:0];
        @(posedge mclk);
        {reg_wr, reg_rd, prio_req, fwd_req} <= 4'h0;
        @(negedge mclk);
        if (k > 0) chk(k == 1 ? reg_rdata_ff : k == 2 ? prio_ff : fwd_ports_ff, e);
        if (k > 0) chk(k == 1 ? reg_rvalid_ff : k == 2 ? prio_valid_ff : fwd_valid_ff, 8'h01);
        @(negedge mclk);
        chk({reg_rvalid_ff, prio_valid_ff, fwd_valid_ff}, 8'h00);
    endtask : op
    task automatic map_all(input logic [15:0] m);
        for (int i = 0; i < MAP_N; i++) op(2, 8'(i), 8'h00, {6'h00, m[2*i +: 2]});
    endtask : map_all
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial begin
        {mclk, resetn, reg_wr, reg_rd, prio_req, fwd_req, fwd_dest_unknown} = 7'h00;
        {reg_addr, reg_wdata, prio_req_pcp, fwd_flood_ports} = 22'h0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        chk(pad_drive_16ma_ff, 8'h01);
        chk({reg_rvalid_ff, prio_valid_ff, fwd_valid_ff}, 8'h00);
        chk(phy_addr_port1_ff, 8'h01);
        chk(phy_addr_port2_ff, 8'h02);
        chk(phy_addr_invalid_ff, 8'h00);
        op(1, LO, 8'h00, 8'h50);
        op(1, UD, 8'h00, 8'h47);
        op(1, PH, 8'h00, 8'h08);
        op(1, 8'h10, 8'h00, READ_UNMAPPED);
        map_all(16'hFA50);
        op(0, UP, 8'h27, 8'h00);
        op(0, LO, 8'hB7, 8'h00);
        map_all(16'h27B7);
        op(0, UD, 8'hFF, 8'h00);
        op(1, UD, 8'h00, 8'hC7);
        op(0, UD, 8'h85, 8'h00);
        chk(pad_drive_16ma_ff, 8'h00);
        op(3, 8'h01, 8'h02, 8'h05);
        op(3, 8'h00, 8'h02, 8'h02);
        op(0, UD, 8'h02, 8'h00);
        op(3, 8'h01, 8'h05, 8'h05);
        op(0, UD, 8'h82, 8'h00);
        op(3, 8'h01, 8'h07, 8'h02);
        op(0, PH, 8'hFF, 8'h00);
        op(1, PH, 8'h00, 8'hF8);
        chk(phy_addr_port2_ff, 8'h00);
        chk(phy_addr_invalid_ff, 8'h01);
        op(0, PH, 8'hE8, 8'h00);
        op(1, PH, 8'h00, 8'hE8);
        chk(phy_addr_port1_ff, 8'h1D);
        chk(phy_addr_port2_ff, 8'h1E);
        final_report();
    end
endmodule : tb
